/* logic/hbridge_ctrl_regs.vh */
// Constants of the H-bridge voltage PWM controller: timing, widths, codes.
// Assumes a 20 MHz core clock; included by the design modules only.
`ifndef HBRIDGE_CTRL_REGS_VH
`define HBRIDGE_CTRL_REGS_VH

// ---------------------------------------------------------------
// Clock and PWM
// ---------------------------------------------------------------
`define CLK_HZ            20000000
`define PWM_FREQ_HZ       44500
`define PWM_PERIOD_CYC    (`CLK_HZ / `PWM_FREQ_HZ)
`define DUTY_W            9
`define DUTY_FULL         9'h1c1

// ---------------------------------------------------------------
// Soft start: 12 ms from zero to full duty
// ---------------------------------------------------------------
`define RAMP_MS           12
`define RAMP_CYC          ((`CLK_HZ / 1000) * `RAMP_MS)
`define RAMP_STEP_CYC     (`RAMP_CYC / 449)

// ---------------------------------------------------------------
// Current limit: 3 us blanking, 275 ms fault deglitch
// ---------------------------------------------------------------
`define ILIM_BLANK_US     3
`define ILIM_BLANK_CYC    ((`CLK_HZ / 1000000) * `ILIM_BLANK_US + 1)
`define ILIM_FAULT_MS     275
`define ILIM_FAULT_CYC    ((`CLK_HZ / 1000) * `ILIM_FAULT_MS)

// ---------------------------------------------------------------
// Overcurrent shutdown deglitch: 2 us
// ---------------------------------------------------------------
`define OCP_US            2
`define OCP_CYC           ((`CLK_HZ / 1000000) * `OCP_US)

// ---------------------------------------------------------------
// Regulation data width and mode codes
// ---------------------------------------------------------------
`define VOLT_W            12
`define MODE_SLEEP        2'h0
`define MODE_REV          2'h1
`define MODE_FWD          2'h2
`define MODE_BRAKE        2'h3

`endif

/* logic/hbridge_voltage_pwm_control.v */
// H-bridge control logic: direction decode, sleep, soft start, voltage loop,
// current limit and overcurrent shutdown with an active-low fault report.
// Assumes all inputs synchronous to i_core_clk; analog compares arrive as
// digital flags or sampled words from converters outside this block.
`timescale 1ns/1ns
`include "hbridge_ctrl_regs.vh"

module hbridge_voltage_pwm_control #(
	parameter ILIM_FAULT_CYC = `ILIM_FAULT_CYC
) (
	input  wire               i_core_clk,
	input  wire               i_rstn,
	input  wire               i_direction_ctrl_a,
	input  wire               i_direction_ctrl_b,
	input  wire [`VOLT_W-1:0] i_motor_voltage_setpoint,
	input  wire [`VOLT_W-1:0] i_bridge_diff_voltage,
	input  wire [`VOLT_W-1:0] i_supply_voltage,
	input  wire               i_current_sense_node_over,
	input  wire               i_switch_overcurrent,
	output reg                o_leg_a_hs_on,
	output reg                o_leg_a_ls_on,
	output reg                o_leg_b_hs_on,
	output reg                o_leg_b_ls_on,
	output reg                o_bridge_leg_a_hiz,
	output reg                o_bridge_leg_b_hiz,
	output reg                o_circuits_awake,
	output reg                o_error_report_low_out,
	output reg                o_error_report_low_oe_n
);

	// ---------------------------------------------------------------
	// Functions
	// ---------------------------------------------------------------

	// Saturating duty step up
	function [`DUTY_W-1:0] duty_up;
		input [`DUTY_W-1:0] d;
		begin
			duty_up = (d >= `DUTY_FULL) ? `DUTY_FULL : d + 9'h001;
		end
	endfunction

	// Saturating duty step down
	function [`DUTY_W-1:0] duty_down;
		input [`DUTY_W-1:0] d;
		begin
			duty_down = (d == 9'h000) ? 9'h000 : d - 9'h001;
		end
	endfunction

	// ---------------------------------------------------------------
	// Mode decode
	// ---------------------------------------------------------------
	wire [1:0] mode;
	wire       driving;
	reg  [1:0] mode_ff;

	assign mode    = {i_direction_ctrl_a, i_direction_ctrl_b};
	assign driving = (mode == `MODE_FWD) || (mode == `MODE_REV);

	always @(posedge i_core_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			mode_ff <= `MODE_SLEEP;
		end else begin
			mode_ff <= mode;
		end
	end

	wire sleep_entry = (mode == `MODE_SLEEP) && (mode_ff != `MODE_SLEEP);
	wire sleep_exit  = (mode != `MODE_SLEEP) && (mode_ff == `MODE_SLEEP);
	// Only a start from sleep or brake restarts; a reversal keeps the ramp
	wire drive_start = driving && ((mode_ff == `MODE_SLEEP) || (mode_ff == `MODE_BRAKE));

	// ---------------------------------------------------------------
	// Carrier and soft-start ramp
	// ---------------------------------------------------------------
	reg  [`DUTY_W-1:0] duty_ff;
	reg  [`DUTY_W-1:0] ramp_cap_ff;
	reg  [15:0]        ramp_cnt_ff;
	wire               pwm_on;
	wire               period_end;
	wire [`DUTY_W-1:0] eff_duty;

	// Duty used by the carrier is bounded by the soft-start ceiling
	assign eff_duty = (duty_ff < ramp_cap_ff) ? duty_ff : ramp_cap_ff;

	pwm_carrier u_carrier (
		.i_core_clk   (i_core_clk),
		.i_rstn       (i_rstn),
		.i_duty       (eff_duty),
		.o_on         (pwm_on),
		.o_period_end (period_end)
	);

	// Counter widened to the 32-bit constant so the compare keeps all bits
	wire ramp_tick = ({16'h0000, ramp_cnt_ff} == (`RAMP_STEP_CYC - 1));

	// Ceiling rises one step per tick, full after about 12 ms
	always @(posedge i_core_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			ramp_cnt_ff <= 16'h0000;
			ramp_cap_ff <= {`DUTY_W{1'b0}};
		end else if (!driving || drive_start) begin
			ramp_cnt_ff <= 16'h0000;
			ramp_cap_ff <= {`DUTY_W{1'b0}};
		end else if (ramp_tick) begin
			ramp_cnt_ff <= 16'h0000;
			ramp_cap_ff <= duty_up(ramp_cap_ff);
		end else begin
			ramp_cnt_ff <= ramp_cnt_ff + 16'h0001;
		end
	end

	// ---------------------------------------------------------------
	// Current limit and overcurrent detection
	// ---------------------------------------------------------------
	wire ilim_active;
	wire ilim_persist;
	wire ocp_hit;

	// Short spikes under 3 us are ignored
	persist_timer #(.LIMIT(`ILIM_BLANK_CYC)) u_ilim_blank (
		.i_core_clk (i_core_clk),
		.i_rstn     (i_rstn),
		.i_cond     (i_current_sense_node_over && driving),
		.o_hit      (ilim_active)
	);

	persist_timer #(.LIMIT(ILIM_FAULT_CYC)) u_ilim_fault (
		.i_core_clk (i_core_clk),
		.i_rstn     (i_rstn),
		.i_cond     (ilim_active),
		.o_hit      (ilim_persist)
	);

	persist_timer #(.LIMIT(`OCP_CYC)) u_ocp (
		.i_core_clk (i_core_clk),
		.i_rstn     (i_rstn),
		.i_cond     (i_switch_overcurrent && driving),
		.o_hit      (ocp_hit)
	);

	// ---------------------------------------------------------------
	// Voltage regulation loop
	// ---------------------------------------------------------------
	reg  [`VOLT_W+1:0] avg_ff;
	wire [`VOLT_W-1:0] avg_div4;
	wire               bypass;

	// Average of differential output, kept as 4x value; top bits are /4
	always @(posedge i_core_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			avg_ff <= {(`VOLT_W+2){1'b0}};
		end else if (!driving) begin
			avg_ff <= {(`VOLT_W+2){1'b0}};
		end else begin
			avg_ff <= avg_ff - {2'b00, avg_ff[`VOLT_W+1:2]} + {2'b00, i_bridge_diff_voltage};
		end
	end

	assign avg_div4 = avg_ff[`VOLT_W+1:2] >> 2;
	// Set-point over a quarter of supply means target above supply
	assign bypass = (i_motor_voltage_setpoint > (i_supply_voltage >> 2));

	// Duty stepped once per PWM period; bypass sets full duty at once
	always @(posedge i_core_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			duty_ff <= {`DUTY_W{1'b0}};
		end else if (!driving || drive_start) begin
			duty_ff <= {`DUTY_W{1'b0}};
		end else if (ilim_active && period_end) begin
			duty_ff <= duty_down(duty_ff);
		end else if (bypass) begin
			duty_ff <= `DUTY_FULL;
		end else if (period_end) begin
			if (avg_div4 < i_motor_voltage_setpoint) begin
				duty_ff <= duty_up(duty_ff);
			end else if (avg_div4 > i_motor_voltage_setpoint) begin
				duty_ff <= duty_down(duty_ff);
			end
		end
	end

	// ---------------------------------------------------------------
	// Faults
	// ---------------------------------------------------------------
	reg ilim_fault_ff;
	reg ocp_latch_ff;
	reg exit_pulse_ff;

	// Current-limit fault: set wins, clears on sleep entry or load removal
	always @(posedge i_core_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			ilim_fault_ff <= 1'b0;
		end else if (ilim_persist) begin
			ilim_fault_ff <= 1'b1;
		end else if (sleep_entry || !ilim_active) begin
			ilim_fault_ff <= 1'b0;
		end
	end

	// Only reset, i.e. a power cycle, releases the shutdown
	always @(posedge i_core_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			ocp_latch_ff <= 1'b0;
		end else if (ocp_hit) begin
			ocp_latch_ff <= 1'b1;
		end
	end

	// One-cycle fault pulse on each exit from sleep
	always @(posedge i_core_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			exit_pulse_ff <= 1'b0;
		end else begin
			exit_pulse_ff <= sleep_exit;
		end
	end

	// ---------------------------------------------------------------
	// Bridge drive and outputs
	// ---------------------------------------------------------------
	reg nxt_a_hs;
	reg nxt_a_ls;
	reg nxt_b_hs;
	reg nxt_b_ls;
	reg nxt_hiz;

	// Switch pattern per mode; off time recirculates on both high sides
	always @* begin
		nxt_a_hs = 1'b0;
		nxt_a_ls = 1'b0;
		nxt_b_hs = 1'b0;
		nxt_b_ls = 1'b0;
		nxt_hiz  = 1'b1;
		if (!ocp_latch_ff && !ocp_hit) begin
			case (mode)
				`MODE_FWD: begin
					nxt_hiz  = 1'b0;
					nxt_a_hs = 1'b1;
					nxt_b_ls = pwm_on;
					nxt_b_hs = !pwm_on;
				end
				`MODE_REV: begin
					nxt_hiz  = 1'b0;
					nxt_b_hs = 1'b1;
					nxt_a_ls = pwm_on;
					nxt_a_hs = !pwm_on;
				end
				`MODE_BRAKE: begin
					nxt_hiz  = 1'b0;
					nxt_a_ls = 1'b1;
					nxt_b_ls = 1'b1;
				end
				default: begin
					nxt_hiz  = 1'b1;
				end
			endcase
		end
	end

	// All outputs registered; sleep drops drivers and internal circuits
	always @(posedge i_core_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			o_leg_a_hs_on           <= 1'b0;
			o_leg_a_ls_on           <= 1'b0;
			o_leg_b_hs_on           <= 1'b0;
			o_leg_b_ls_on           <= 1'b0;
			o_bridge_leg_a_hiz      <= 1'b1;
			o_bridge_leg_b_hiz      <= 1'b1;
			o_circuits_awake        <= 1'b0;
			o_error_report_low_out  <= 1'b0;
			o_error_report_low_oe_n <= 1'b1;
		end else begin
			o_leg_a_hs_on           <= nxt_a_hs;
			o_leg_a_ls_on           <= nxt_a_ls;
			o_leg_b_hs_on           <= nxt_b_hs;
			o_leg_b_ls_on           <= nxt_b_ls;
			o_bridge_leg_a_hiz      <= nxt_hiz;
			o_bridge_leg_b_hiz      <= nxt_hiz;
			o_circuits_awake        <= (mode != `MODE_SLEEP);
			o_error_report_low_out  <= 1'b0;
			// Open drain: pull low while any fault source is active
			o_error_report_low_oe_n <= !(ilim_fault_ff || ocp_latch_ff || ocp_hit || exit_pulse_ff);
		end
	end

endmodule // hbridge_voltage_pwm_control

/* logic/persist_timer.v */
// Persistence timer: holds o_hit high while i_cond has held for LIMIT cycles.
// Assumes i_cond is synchronous to i_core_clk.
`timescale 1ns/1ns

module persist_timer #(
	parameter LIMIT = 32'd60
) (
	input  wire        i_core_clk,
	input  wire        i_rstn,
	input  wire        i_cond,
	output wire        o_hit
);

	reg  [31:0] cnt_ff;
	wire [31:0] nxt_cnt;

	// Restart whenever the condition drops; saturate at the limit
	assign nxt_cnt = !i_cond ? 32'h0000_0000 :
		(cnt_ff >= LIMIT) ? cnt_ff : cnt_ff + 32'h0000_0001;

	always @(posedge i_core_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			cnt_ff <= 32'h0000_0000;
		end else begin
			cnt_ff <= nxt_cnt;
		end
	end

	// Level, high while the condition has persisted long enough
	assign o_hit = i_cond && (cnt_ff >= LIMIT);

endmodule // persist_timer

/* logic/pwm_carrier.v */
// Free-running PWM carrier at the internal switching frequency.
// Assumes a 20 MHz core clock; duty compared against the count.
`timescale 1ns/1ns
`include "hbridge_ctrl_regs.vh"

module pwm_carrier (
	input  wire                i_core_clk,
	input  wire                i_rstn,
	input  wire [`DUTY_W-1:0]  i_duty,
	output wire                o_on,
	output wire                o_period_end
);

	reg  [`DUTY_W-1:0] cnt_ff;
	wire               wrap;

	assign wrap = (cnt_ff == (`DUTY_FULL - 9'h001));

	// Count 0..DUTY_FULL-1, one full period per wrap
	always @(posedge i_core_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			cnt_ff <= {`DUTY_W{1'b0}};
		end else if (wrap) begin
			cnt_ff <= {`DUTY_W{1'b0}};
		end else begin
			cnt_ff <= cnt_ff + 9'h001;
		end
	end

	// Duty of DUTY_FULL keeps the on phase through the whole period
	assign o_on         = (cnt_ff < i_duty);
	assign o_period_end = wrap;

endmodule // pwm_carrier

/* verification/hbridge_ctrl_sva.sv */
// Port checker for the H-bridge voltage PWM controller.
// Bound from the bench; one clock domain, async active-low reset.
`timescale 1ns/1ns

module hbridge_ctrl_sva #(
	parameter ILIM_FAULT_CYC = 200
) (
	input wire logic i_core_clk,
	input wire logic i_rstn,
	input wire logic i_direction_ctrl_a,
	input wire logic i_direction_ctrl_b,
	input wire logic i_current_sense_node_over,
	input wire logic i_switch_overcurrent,
	input wire logic o_leg_a_hs_on,
	input wire logic o_leg_a_ls_on,
	input wire logic o_leg_b_hs_on,
	input wire logic o_leg_b_ls_on,
	input wire logic o_bridge_leg_a_hiz,
	input wire logic o_bridge_leg_b_hiz,
	input wire logic o_circuits_awake,
	input wire logic o_error_report_low_oe_n
);
	// ----------------
	// Run-length helpers
	// ----------------
	// Counters keep long waits out of repetition operators
	wire  drv = i_direction_ctrl_a ^ i_direction_ctrl_b;
	wire  ina = i_direction_ctrl_a;
	wire  inb = i_direction_ctrl_b;
	logic ocp_seen_ff;
	logic ocp_hit_ff;
	int   drv_cnt_ff;
	int   oc_cnt_ff;
	int   il_cnt_ff;
	int   calm_cnt_ff;
	always_ff @(posedge i_core_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			ocp_seen_ff <= 1'b0;
			ocp_hit_ff <= 1'b0;
			drv_cnt_ff <= 0;
			oc_cnt_ff <= 0;
			il_cnt_ff <= 0;
			calm_cnt_ff <= 0;
		end else begin
			ocp_seen_ff <= ocp_seen_ff | i_switch_overcurrent;
			ocp_hit_ff <= ocp_hit_ff | (oc_cnt_ff >= 45); // Slack over the 40-cycle deglitch
			drv_cnt_ff <= drv ? drv_cnt_ff + 1 : 0;
			oc_cnt_ff <= (drv && i_switch_overcurrent) ? oc_cnt_ff + 1 : 0;
			il_cnt_ff <= (drv && i_current_sense_node_over) ? il_cnt_ff + 1 : 0;
			calm_cnt_ff <= (i_current_sense_node_over || !o_circuits_awake) ? 0 : calm_cnt_ff + 1;
		end
	end

	default clocking cb @(posedge i_core_clk);
	endclocking
	default disable iff (!i_rstn);

	// ----------------
	// Bridge state
	// ----------------
	a_sleep_off: assert property (
		!ina && !inb |=> o_bridge_leg_a_hiz && o_bridge_leg_b_hiz && !o_circuits_awake
		&& !o_leg_a_hs_on && !o_leg_a_ls_on && !o_leg_b_hs_on && !o_leg_b_ls_on)
		else $error("sleep did not float the bridge");
	a_brake_low: assert property (
		ina && inb && !ocp_seen_ff |=> o_leg_a_ls_on && o_leg_b_ls_on && !o_leg_a_hs_on && !o_leg_b_hs_on)
		else $error("brake did not close both low sides");
	a_fwd_drive: assert property (
		ina && !inb && !ocp_seen_ff |=> o_leg_a_hs_on && !o_leg_a_ls_on && o_circuits_awake
		&& (o_leg_b_hs_on != o_leg_b_ls_on) && !o_bridge_leg_a_hiz && !o_bridge_leg_b_hiz)
		else $error("forward leg pattern wrong");
	a_rev_drive: assert property (
		!ina && inb && !ocp_seen_ff |=> o_leg_b_hs_on && !o_leg_b_ls_on && o_circuits_awake
		&& (o_leg_a_hs_on != o_leg_a_ls_on) && !o_bridge_leg_a_hiz && !o_bridge_leg_b_hiz)
		else $error("reverse leg pattern wrong");
	a_soft_start: assert property (
		drv_cnt_ff >= 1 && drv_cnt_ff <= 400 |-> !o_leg_a_ls_on && !o_leg_b_ls_on)
		else $error("drive began above zero duty");
	a_ocp_latch: assert property (
		ocp_hit_ff |-> !o_leg_a_hs_on && !o_leg_a_ls_on && !o_leg_b_hs_on && !o_leg_b_ls_on
		&& o_bridge_leg_a_hiz && o_bridge_leg_b_hiz && !o_error_report_low_oe_n)
		else $error("overcurrent shutdown not held");

	// ----------------
	// Fault report
	// ----------------
	a_wake_pulse: assert property (
		$rose(o_circuits_awake) |=> !o_error_report_low_oe_n)
		else $error("no fault pulse on sleep exit");
	a_sleep_clear: assert property (
		!o_circuits_awake && $past(!o_circuits_awake) && !ocp_seen_ff |-> o_error_report_low_oe_n)
		else $error("fault held during sleep");
	a_ilim_report: assert property (
		il_cnt_ff >= ILIM_FAULT_CYC + 75 |-> !o_error_report_low_oe_n)
		else $error("current limit fault not reported");
	a_fault_free: assert property (
		calm_cnt_ff >= 4 && !ocp_seen_ff |-> o_error_report_low_oe_n)
		else $error("fault line low with no cause");

	cover property ($rose(o_circuits_awake));
	cover property (ocp_hit_ff);
	cover property (il_cnt_ff > 0 && !o_error_report_low_oe_n);
endmodule // hbridge_ctrl_sva

/* verification/hbridge_host_model.sv */
// Host model: drives the two direction lines and counts fault pulses.
// Assumes the bench supplies the clock and an open-drain fault level.
`timescale 1ns/1ns

module hbridge_host_model (
	input  wire logic       i_core_clk,
	input  wire logic [1:0] i_cmd,
	input  wire logic       i_pwm_en,
	input  wire logic       i_sloppy,
	input  wire logic       i_fault_line,
	output logic            o_dir_a,
	output logic            o_dir_b,
	output int              o_fault_pulses
);
	// Slow toggle only; fast input chopping would fight the soft start
	localparam int HALF = 64;
	int   ph_ff = 0;
	logic tog_ff = 1'b0;
	logic fault_q_ff = 1'b1;
	initial begin
		o_dir_a = 1'b0;
		o_dir_b = 1'b0;
		o_fault_pulses = 0;
	end
	// Direction drive and fault edge count
	always @(posedge i_core_clk) begin
		ph_ff <= (ph_ff == HALF - 1) ? 0 : ph_ff + 1;
		if (ph_ff == HALF - 1)
			tog_ff <= !tog_ff;
		fault_q_ff <= i_fault_line;
		if (fault_q_ff && !i_fault_line)
			o_fault_pulses <= o_fault_pulses + 1;
		if (i_pwm_en) begin
			o_dir_a <= tog_ff;
			o_dir_b <= !i_sloppy;
		end else begin
			{o_dir_a, o_dir_b} <= i_cmd;
		end
	end
endmodule // hbridge_host_model

/* verification/hbridge_voltage_pwm_control_test.sv */
// Self-checking bench for the H-bridge voltage PWM controller.
// Bench drives analog words and flags; the host model drives direction.
`timescale 1ns/1ns

module hbridge_voltage_pwm_control_test;
	localparam int ILIM = 200;
	logic        i_core_clk = 1'b0;
	logic        i_rstn = 1'b0;
	logic [11:0] set_v = 12'h000;
	logic [11:0] diff_v = 12'h000;
	logic [11:0] sup_v = 12'hfff;
	logic        sense = 1'b0;
	logic        ocur = 1'b0;
	logic        pwm_en = 1'b0;
	logic        sloppy = 1'b0;
	logic [1:0]  cmd = 2'h0;
	wire         dir_a, dir_b, a_hs, a_ls, b_hs, b_ls, hiz_a, hiz_b, awake, flt_out, flt_oe_n;
	int          pulses;
	int          failures = 0;
	int          cmp_count = 0;
	// Open-drain fault line with its pull-up
	wire       fault_line = flt_oe_n ? 1'b1 : flt_out;
	wire [6:0] seen_out = {hiz_a, hiz_b, a_hs, a_ls, b_hs, b_ls, awake};

	always #25 i_core_clk = ~i_core_clk;

	hbridge_voltage_pwm_control #(.ILIM_FAULT_CYC(ILIM)) dut (
		.i_core_clk(i_core_clk), .i_rstn(i_rstn), .i_direction_ctrl_a(dir_a), .i_direction_ctrl_b(dir_b),
		.i_motor_voltage_setpoint(set_v), .i_bridge_diff_voltage(diff_v), .i_supply_voltage(sup_v),
		.i_current_sense_node_over(sense), .i_switch_overcurrent(ocur), .o_leg_a_hs_on(a_hs),
		.o_leg_a_ls_on(a_ls), .o_leg_b_hs_on(b_hs), .o_leg_b_ls_on(b_ls), .o_bridge_leg_a_hiz(hiz_a),
		.o_bridge_leg_b_hiz(hiz_b), .o_circuits_awake(awake), .o_error_report_low_out(flt_out),
		.o_error_report_low_oe_n(flt_oe_n));

	hbridge_host_model host (.i_core_clk(i_core_clk), .i_cmd(cmd), .i_pwm_en(pwm_en), .i_sloppy(sloppy),
		.i_fault_line(fault_line), .o_dir_a(dir_a), .o_dir_b(dir_b), .o_fault_pulses(pulses));

	// ----------------
	// Checking and expectations
	// ----------------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			failures++;
			$display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
		end
	endtask
	task automatic final_report;
		$display("Counts: %0d compares, %0d mismatches", cmp_count, failures);
		if (failures == 0 && cmp_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// Bridge state while duty is still zero
	function automatic logic [6:0] exp_out(input logic [1:0] m);
		case (m)
			2'h0: return 7'b1100000;
			2'h3: return 7'b0001011;
			default: return 7'b0010101;
		endcase
	endfunction
	// Bypass gives on time; a zero set-point never raises duty
	function automatic logic exp_run(input logic [11:0] s, input logic [11:0] v);
		return s > (v >> 2);
	endfunction

	// ----------------
	// Stimulus tasks
	// ----------------
	// Mode change through the host: wake pulse, then settled state
	task automatic step(input logic [1:0] m);
		logic wake;
		wake = (cmd == 2'h0) && (m != 2'h0);
		@(posedge i_core_clk);
		cmd <= m;
		repeat (4) @(negedge i_core_clk);
		if (wake) check(fault_line, 1'b0);
		@(negedge i_core_clk);
		check({seen_out, fault_line}, {exp_out(m), 1'b1});
	endtask
	// Bounded wait for a fault line level
	task automatic wait_line(input logic lvl, input int lim, output int n);
		n = 0;
		while (fault_line !== lvl) begin
			if (n == lim) begin
				failures++;
				$display("Error at %0t: fault line wait ran out", $time);
				final_report();
			end
			@(negedge i_core_clk);
			n++;
		end
	endtask
	// One regulation run, on time measured over a PWM period
	task automatic trial(input logic bypass);
		int on;
		logic [11:0] s, v;
		on = 0;
		v = 12'($urandom_range(4095, 256));
		s = bypass ? v / 4 + 12'($urandom_range(16, 1)) : 12'h000;
		step(2'h0);
		@(posedge i_core_clk);
		sup_v <= v;
		set_v <= s;
		diff_v <= 12'($urandom);
		step(($urandom_range(1) != 0) ? 2'h2 : 2'h1);
		repeat (5500) @(negedge i_core_clk);
		repeat (449) begin
			@(negedge i_core_clk);
			if (a_ls !== 1'b0 || b_ls !== 1'b0) on++;
		end
		check(on > 0, exp_run(s, v));
	endtask

	// ----------------
	// Main sequence
	// ----------------
	initial begin
		int n, exits, p0;
		logic [1:0] prev;
		void'($urandom(9580));
		repeat (20) @(negedge i_core_clk);
		check({seen_out, fault_line}, 8'hc1);
		@(posedge i_core_clk);
		i_rstn <= 1'b1;
		@(negedge i_core_clk);
		for (int i = 0; i < 10; i++)
			step(i < 4 ? 2'(i) : 2'($urandom_range(3)));
		$display("decode test done");
		for (int i = 0; i < 4; i++)
			trial(i[0]);
		$display("regulation test done");
		step(2'h0);
		step(2'h2);
		@(posedge i_core_clk);
		sense <= 1'b1;
		wait_line(1'b0, ILIM + 80, n);
		check(n >= ILIM, 1'b1);
		// Hold the overload a little longer so the report assertion is reached
		repeat (20) @(posedge i_core_clk);
		sense <= 1'b0;
		wait_line(1'b1, 6, n);
		@(posedge i_core_clk);
		sense <= 1'b1;
		wait_line(1'b0, ILIM + 80, n);
		step(2'h0);
		@(posedge i_core_clk);
		sense <= 1'b0;
		$display("limit test done");
		for (int k = 0; k < 2; k++) begin
			p0 = pulses;
			exits = 0;
			@(posedge i_core_clk);
			sloppy <= (k == 0);
			pwm_en <= 1'b1;
			prev = 2'h0;
			for (int j = 0; j < 530; j++) begin
				@(posedge i_core_clk);
				if (j == 520) pwm_en <= 1'b0;
				@(negedge i_core_clk);
				if (prev == 2'h0 && {dir_a, dir_b} != 2'h0) exits++;
				prev = {dir_a, dir_b};
			end
			check(pulses - p0, exits);
		end
		$display("host pwm test done");
		step(2'h2);
		@(posedge i_core_clk);
		ocur <= 1'b1;
		repeat (50) @(negedge i_core_clk);
		check({seen_out[6:1], fault_line}, 7'b1100000);
		@(posedge i_core_clk);
		ocur <= 1'b0;
		cmd <= 2'h3;
		repeat (5) @(negedge i_core_clk);
		check({seen_out[6:1], fault_line}, 7'b1100000);
		$display("overcurrent test done");
		final_report();
	end
endmodule // hbridge_voltage_pwm_control_test

bind hbridge_voltage_pwm_control hbridge_ctrl_sva #(.ILIM_FAULT_CYC(ILIM_FAULT_CYC)) chk (
	.i_core_clk(i_core_clk), .i_rstn(i_rstn), .i_direction_ctrl_a(i_direction_ctrl_a),
	.i_direction_ctrl_b(i_direction_ctrl_b), .i_current_sense_node_over(i_current_sense_node_over),
	.i_switch_overcurrent(i_switch_overcurrent), .o_leg_a_hs_on(o_leg_a_hs_on), .o_leg_a_ls_on(o_leg_a_ls_on),
	.o_leg_b_hs_on(o_leg_b_hs_on), .o_leg_b_ls_on(o_leg_b_ls_on), .o_bridge_leg_a_hiz(o_bridge_leg_a_hiz),
	.o_bridge_leg_b_hiz(o_bridge_leg_b_hiz), .o_circuits_awake(o_circuits_awake),
	.o_error_report_low_oe_n(o_error_report_low_oe_n));
